// ==== src/vidc_cfg.svh ====
// Purpose: Constants of the voltage identification code block
// Assumes: 250 MHz system clock
// Notes:   Timing counts are derived from times in their own unit
`ifndef VIDC_CFG_SVH
`define VIDC_CFG_SVH

// Widths of the two codes
`define VIDC_CORE_W          6
`define VIDC_CACHE_W         4
// Highest core level index (62 levels, 12.5 mV apart)
`define VIDC_CORE_MAX_IDX    6'h3D
// Core field values used by the index to code mapping and the off check
`define VIDC_CORE_F_BASE     5'h0A
`define VIDC_CORE_F_SKIP     5'h0B
`define VIDC_CORE_OFF_LOW    5'h1F
// Cache codes: off, and the lowest level (1.100 V)
`define VIDC_CACHE_OFF       4'hF
`define VIDC_CACHE_BASE      4'hE
`define VIDC_CACHE_MAX_SEL   4'hE
// Reset level index of the core code (lowest level)
`define VIDC_CORE_RST_IDX    6'h00
// Core code of the reset level index (0.8375 V)
`define VIDC_CORE_RST_CODE   6'h0A
// Clock period and least dwell between two core steps
`define VIDC_CLK_PERIOD_PS   4000
`define VIDC_STEP_DWELL_NS   5000
`define VIDC_STEP_DWELL_CYC  ((`VIDC_STEP_DWELL_NS * 1000 + `VIDC_CLK_PERIOD_PS - 1) / `VIDC_CLK_PERIOD_PS)
// Cycles spent in boot before the straps are taken
`define VIDC_BOOT_CYC        2'h3

`endif

// ==== src/vidc_pkg.sv ====
// Purpose: Types of the voltage identification code block
// Assumes: Constants live in vidc_cfg.svh
// Notes:   Nothing here is imported; use vidc_pkg::name
package vidc_pkg;

    // Sequencer states
    typedef enum logic [1:0]
    {
        VIDC_BOOT,
        VIDC_IDLE,
        VIDC_STEP
    } vidc_state_t;

endpackage : vidc_pkg

// ==== src/vidc_od_pad.sv ====
// Purpose: Open-drain drive and read-back of one voltage code
// Assumes: Pull-ups on the board give the high level
// Notes:   Read-back passes two flip-flops before comparison
`timescale 1ns/1ps
module vidc_od_pad #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Code to present
    input  wire logic [W-1:0] code,
    // Pad signals
    input  wire logic [W-1:0] pad_in,
    output logic      [W-1:0] pad_out,
    output logic      [W-1:0] pad_oe_n,
    // Read-back disagrees with the code
    output logic              mismatch_q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Refuse an empty code at elaboration
    if (W < 1)
    begin : g_bad_w
        $error("vidc_od_pad: W must be at least 1");
    end

    // Per bit: pull low for a zero, release for a one
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign pad_out[i]  = 1'b0;
        assign pad_oe_n[i] = code[i];
    end

    // Two-stage read-back synchroniser
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= pad_in;
            sync_q <= meta_q;
        end
    end

    // Compare settled read-back with the code
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mismatch_q <= 1'b0;
        end
        else if (clk_en)
        begin
            mismatch_q <= (sync_q != code);
        end
    end

endmodule : vidc_od_pad

// ==== src/vidc_top.sv ====
// Purpose: Drives the core and cache voltage codes to the regulators
// Assumes: Straps are pins; the target level comes from logic on sys_clk
// Notes:   Core levels are indices, 0 = 0.8375 V, 61 = 1.6000 V
`timescale 1ns/1ps
`include "vidc_cfg.svh"

module vidc_top #(
    parameter int DWELL_CYC = `VIDC_STEP_DWELL_CYC
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Straps from pins
    input  wire logic [5:0]  default_level_strap,
    input  wire logic [3:0]  cache_level_strap,
    input  wire logic        cache_present_strap,
    // Target core level from on-chip logic
    input  wire logic [5:0]  target_level,
    // Core code pads
    input  wire logic [5:0]  core_voltage_code_bits_in,
    output logic      [5:0]  core_voltage_code_bits_out,
    output logic      [5:0]  core_voltage_code_bits_oe_n,
    // Cache code pads
    input  wire logic [3:0]  cache_voltage_code_bits_in,
    output logic      [3:0]  cache_voltage_code_bits_out,
    output logic      [3:0]  cache_voltage_code_bits_oe_n,
    // Status
    output logic      [5:0]  core_level_q,
    output logic      [5:0]  core_voltage_code_q,
    output logic      [3:0]  cache_voltage_code_q,
    output logic             busy,
    output logic             pad_mismatch
);

    localparam logic [15:0] DWELL_LOAD = 16'(DWELL_CYC - 1);

    vidc_pkg::vidc_state_t state_q;
    logic [1:0]  boot_cnt_q;
    logic [10:0] strap_meta_q;
    logic [10:0] strap_sync_q;
    logic [5:0]  dflt_q;
    logic [5:0]  dflt_d;
    logic [5:0]  goal;
    logic [5:0]  level_d;
    logic [15:0] dwell_q;
    logic        core_mis;
    logic        cache_mis;

    // Refuse a dwell the counter and checks cannot serve
    if (DWELL_CYC < 8 || DWELL_CYC > 65535)
    begin : g_bad_dwell
        $error("vidc_top: DWELL_CYC must be 8 to 65535");
    end

    // Level index to six-bit core code
    function automatic logic [5:0] idx2code(input logic [5:0] k);
        logic [5:0] t;
        logic [4:0] h;
        logic [4:0] f;
        t = k + 6'h01;
        h = t[5:1];
        f = `VIDC_CORE_F_BASE - h - ((h >= `VIDC_CORE_F_SKIP) ? 5'h01 : 5'h00);
        return {~t[0], f};
    endfunction : idx2code

    // Strap synchroniser
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end
        else if (clk_en)
        begin
            strap_meta_q <= {cache_present_strap, cache_level_strap, default_level_strap};
            strap_sync_q <= strap_meta_q;
        end
    end

    // Default clamped to the highest level
    assign dflt_d = (strap_sync_q[5:0] > `VIDC_CORE_MAX_IDX) ? `VIDC_CORE_MAX_IDX
                                                              : strap_sync_q[5:0];
    // Goal never above the default
    assign goal   = (target_level > dflt_q) ? dflt_q : target_level;

    // Sequencer state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q    <= vidc_pkg::VIDC_BOOT;
            boot_cnt_q <= 2'h0;
        end
        else if (clk_en)
        begin
            case (state_q)
                vidc_pkg::VIDC_BOOT:
                begin
                    boot_cnt_q <= boot_cnt_q + 2'h1;
                    if (boot_cnt_q == `VIDC_BOOT_CYC)
                    begin
                        state_q <= vidc_pkg::VIDC_IDLE;
                    end
                end
                vidc_pkg::VIDC_IDLE:
                begin
                    if (goal != core_level_q)
                    begin
                        state_q <= vidc_pkg::VIDC_STEP;
                    end
                end
                vidc_pkg::VIDC_STEP:
                begin
                    if (goal == core_level_q && dwell_q == 16'h0)
                    begin
                        state_q <= vidc_pkg::VIDC_IDLE;
                    end
                end
                default:
                begin
                    state_q <= vidc_pkg::VIDC_BOOT;
                end
            endcase
        end
    end

    // Next level: boot load, or one adjacent step
    always_comb
    begin
        level_d = core_level_q;
        if (state_q == vidc_pkg::VIDC_BOOT)
        begin
            if (boot_cnt_q == `VIDC_BOOT_CYC)
            begin
                level_d = dflt_d;
            end
        end
        else if (dwell_q == 16'h0 && goal > core_level_q)
        begin
            level_d = core_level_q + 6'h01;
        end
        else if (dwell_q == 16'h0 && goal < core_level_q)
        begin
            level_d = core_level_q - 6'h01;
        end
    end

    // Default capture at end of boot
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dflt_q <= `VIDC_CORE_RST_IDX;
        end
        else if (clk_en && state_q == vidc_pkg::VIDC_BOOT && boot_cnt_q == `VIDC_BOOT_CYC)
        begin
            dflt_q <= dflt_d;
        end
    end

    // Core level and its code
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            core_level_q        <= `VIDC_CORE_RST_IDX;
            core_voltage_code_q <= `VIDC_CORE_RST_CODE;
        end
        else if (clk_en)
        begin
            core_level_q        <= level_d;
            core_voltage_code_q <= idx2code(level_d);
        end
    end

    // Dwell timer between steps
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dwell_q <= 16'h0;
        end
        else if (clk_en)
        begin
            if (state_q != vidc_pkg::VIDC_BOOT && level_d != core_level_q)
            begin
                dwell_q <= DWELL_LOAD;
            end
            else if (dwell_q != 16'h0)
            begin
                dwell_q <= dwell_q - 16'h1;
            end
        end
    end

    // Cache code fixed at boot from the configuration straps
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cache_voltage_code_q <= `VIDC_CACHE_OFF;
        end
        else if (clk_en && state_q == vidc_pkg::VIDC_BOOT && boot_cnt_q == `VIDC_BOOT_CYC)
        begin
            if (!strap_sync_q[10])
            begin
                cache_voltage_code_q <= `VIDC_CACHE_OFF;
            end
            else if (strap_sync_q[9:6] > `VIDC_CACHE_MAX_SEL)
            begin
                cache_voltage_code_q <= 4'h0;
            end
            else
            begin
                cache_voltage_code_q <= `VIDC_CACHE_BASE - strap_sync_q[9:6];
            end
        end
    end

    assign busy         = (state_q != vidc_pkg::VIDC_IDLE);
    assign pad_mismatch = core_mis | cache_mis;

    // Open-drain pads of both codes
    vidc_od_pad #(.W(6)) u_core_pad (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .code       (core_voltage_code_q),
        .pad_in     (core_voltage_code_bits_in),
        .pad_out    (core_voltage_code_bits_out),
        .pad_oe_n   (core_voltage_code_bits_oe_n),
        .mismatch_q (core_mis)
    );

    vidc_od_pad #(.W(4)) u_cache_pad (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .code       (cache_voltage_code_q),
        .pad_in     (cache_voltage_code_bits_in),
        .pad_out    (cache_voltage_code_bits_out),
        .pad_oe_n   (cache_voltage_code_bits_oe_n),
        .mismatch_q (cache_mis)
    );

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_core_never_off: assert property (core_voltage_code_q[4:0] != `VIDC_CORE_OFF_LOW)
        else $error("core code selects regulator off");
    a_core_code_map: assert property (core_voltage_code_q == idx2code(core_level_q))
        else $error("core code does not match level");
    a_step_adjacent: assert property ($past(state_q) != vidc_pkg::VIDC_BOOT && $changed(core_level_q)
        |-> (core_level_q == $past(core_level_q) + 6'h01
          || core_level_q == $past(core_level_q) - 6'h01))
        else $error("core step not adjacent");
    a_step_dwell: assert property ($past(state_q) != vidc_pkg::VIDC_BOOT && $changed(core_level_q)
        |=> $stable(core_level_q)[*7])
        else $error("core steps too close");
    a_below_default: assert property (state_q != vidc_pkg::VIDC_BOOT |-> core_level_q <= dflt_q)
        else $error("core level above default");
    a_boot_default: assert property (clk_en && state_q == vidc_pkg::VIDC_BOOT
        && boot_cnt_q == `VIDC_BOOT_CYC |=> core_level_q == dflt_q)
        else $error("default not loaded at boot");
    a_cache_map: assert property (clk_en && state_q == vidc_pkg::VIDC_BOOT
        && boot_cnt_q == `VIDC_BOOT_CYC && strap_sync_q[10] && strap_sync_q[9:6] <= 4'hE
        |=> cache_voltage_code_q == 4'hE - $past(strap_sync_q[9:6]))
        else $error("cache code mapping wrong");
    a_cache_fixed: assert property (state_q != vidc_pkg::VIDC_BOOT |=> $stable(cache_voltage_code_q))
        else $error("cache code changed after boot");

    c_step_up:   cover property (state_q == vidc_pkg::VIDC_STEP && level_d > core_level_q);
    c_step_down: cover property (state_q == vidc_pkg::VIDC_STEP && level_d < core_level_q);
    c_cache_off: cover property (cache_voltage_code_q == `VIDC_CACHE_OFF && state_q == vidc_pkg::VIDC_IDLE);

endmodule : vidc_top

// ==== sim/vidc_reg_model.sv ====
// Purpose: Regulator-side decoders for the core and cache codes
// Assumes: Code wires already resolved with the board pull-ups
// Notes:   Unmet requests are not modelled; off only raises a flag
`timescale 1ns/1ps
module vidc_reg_model #(
    parameter int STABLE = 3
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Code wires, high level reads as one
    input  wire logic [5:0] core_wire,
    input  wire logic [3:0] cache_wire,
    // Accepted codes and off flags
    output logic      [5:0] core_code_q,
    output logic      [5:0] cache_code_q,
    output logic            core_off,
    output logic            cache_off
);
    logic [11:0] seen_q;
    logic [3:0]  cnt_q;
    logic [11:0] bus;

    // Extra cache decoder inputs held high by the board
    assign bus = {core_wire, 2'h3, cache_wire};

    // Accept a code only after it stays equal for STABLE + 2 samples
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            seen_q       <= 12'hFFF;
            cnt_q        <= 4'h0;
            core_code_q  <= 6'h3F;
            cache_code_q <= 6'h3F;
        end
        else if (bus != seen_q)
        begin
            seen_q <= bus;
            cnt_q  <= 4'h0;
        end
        else if (cnt_q < STABLE)
            cnt_q <= cnt_q + 4'h1;
        else
        begin
            core_code_q  <= seen_q[11:6];
            cache_code_q <= seen_q[5:0];
        end
    end

    // Off decodes
    assign core_off  = &core_code_q[4:0];
    assign cache_off = (cache_code_q == 6'h3F);
endmodule : vidc_reg_model

// ==== sim/vidc_top_tb_top.sv ====
// Purpose: Self-checking bench of the voltage code block
// Assumes: Pull-ups on both code buses, short dwell
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module vidc_top_tb_top;
    localparam int DW = 8;
    logic       sys_clk;
    logic       rst;
    logic       clk_en;
    logic [5:0] def_s;
    logic [3:0] cch_s;
    logic       pres_s;
    logic [5:0] target;
    logic [5:0] stuck;
    logic [3:0] cstuck;
    logic [5:0] core_out;
    logic [5:0] core_oe_n;
    logic [3:0] cch_out;
    logic [3:0] cch_oe_n;
    logic [5:0] lvl;
    logic [5:0] code;
    logic [3:0] cch_code;
    logic       busy;
    logic       pad_mm;
    logic [5:0] m_core;
    logic [5:0] m_cch;
    logic       core_off;
    logic       cch_off;
    logic       armed;
    logic [5:0] prev;
    logic [5:0] exp_def;
    logic [3:0] exp_cch;
    int         hold;
    int         fails;
    int         checked;
    wire  [5:0] core_wire = (core_oe_n | core_out) & ~stuck;
    wire  [3:0] cch_wire  = (cch_oe_n | cch_out) & ~cstuck;

    vidc_top #(.DWELL_CYC(DW)) vidc_top_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .default_level_strap(def_s), .cache_level_strap(cch_s), .cache_present_strap(pres_s),
        .target_level(target), .core_voltage_code_bits_in(core_wire),
        .core_voltage_code_bits_out(core_out), .core_voltage_code_bits_oe_n(core_oe_n),
        .cache_voltage_code_bits_in(cch_wire), .cache_voltage_code_bits_out(cch_out),
        .cache_voltage_code_bits_oe_n(cch_oe_n), .core_level_q(lvl), .core_voltage_code_q(code),
        .cache_voltage_code_q(cch_code), .busy(busy), .pad_mismatch(pad_mm));

    vidc_reg_model vidc_reg_model_inst (.sys_clk(sys_clk), .rst(rst), .core_wire(core_wire),
        .cache_wire(cch_wire), .core_code_q(m_core), .cache_code_q(m_cch),
        .core_off(core_off), .cache_off(cch_off));

    // Code of a level index, from the code table
    function automatic logic [5:0] exp_code(input logic [5:0] k);
        logic [5:0] h;
    begin
        h = (k + 6'h01) >> 1;
        return {k[0], 5'h0A - h[4:0] - {4'h0, h >= 6'h0B}};
    end
    endfunction : exp_code

    task automatic check_vec(input string nm, input logic [5:0] e, input logic [5:0] g);
    begin
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    end
    endtask : check_vec

    task automatic check_flag(input string nm, input logic e, input logic g);
    begin
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    end
    endtask : check_flag

    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask : report_and_stop

    task automatic wait_flag(input string nm, input logic v, input int lim);
        int n;
    begin
        n = 0;
        while (busy !== 1'b0 && nm == "busy" && n < lim || nm != "busy" && pad_mm !== v && n < lim)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        // Timed out only if the awaited level never came
        if ((nm == "busy") ? (busy !== 1'b0) : (pad_mm !== v))
        begin
            check_flag(nm, v, ~v);
            report_and_stop();
        end
    end
    endtask : wait_flag

    // Reset, boot with the given straps, then arm the monitor
    task automatic boot(input logic [5:0] d, input logic [3:0] c, input logic p);
    begin
        armed = 0;
        rst = 1;
        def_s = d;
        cch_s = c;
        pres_s = p;
        target = d;
        exp_def = (d > 6'h3D) ? 6'h3D : d;
        exp_cch = !p ? 4'hF : (c == 4'hF) ? 4'h0 : 4'hE - c;
        repeat (12) @(posedge sys_clk);
        #1;
        check_vec("reset core code", 6'h0A, core_oe_n);
        check_vec("reset cache code", 6'h0F, {2'h0, cch_oe_n});
        check_flag("reset busy", 1'b1, busy);
        check_flag("reset mismatch", 1'b0, pad_mm);
        rst = 0;
        repeat (12) @(posedge sys_clk);
        #1;
        check_vec("boot level", exp_def, lvl);
        check_vec("cache code", {2'h0, exp_cch}, {2'h0, cch_code});
        check_vec("regulator cache", {2'h3, exp_cch}, m_cch);
        check_flag("cache off", exp_cch == 4'hF, cch_off);
        prev = lvl;
        hold = DW;
        armed = 1;
    end
    endtask : boot

    // Move to a goal; fresh means the block starts idle
    task automatic step_to(input logic [5:0] goal, input logic [5:0] fin, input logic fresh);
        logic [5:0] s;
    begin
        s = lvl;
        target = goal;
        @(posedge sys_clk);
        #1;
        if (fresh && s != fin)
            check_vec("first step", fin > s ? s + 6'h01 : s - 6'h01, lvl);
        wait_flag("busy", 1'b0, 800);
        check_vec("final level", fin, lvl);
        repeat (6) @(posedge sys_clk);
        #1;
        check_vec("regulator core", exp_code(fin), m_core);
    end
    endtask : step_to

    // Freeze the clock enable mid-sequence; nothing may move
    task automatic freeze_check;
        logic [5:0] sv;
    begin
        repeat (2 * DW) @(posedge sys_clk);
        #1 clk_en = 0;
        sv = lvl;
        repeat (20) @(posedge sys_clk);
        #1 check_vec("frozen level", sv, lvl);
        clk_en = 1;
    end
    endtask : freeze_check

    // Another party holds one pad of each code low, then lets go
    task automatic pad_check;
    begin
        stuck = 6'h01;
        wait_flag("core pad mismatch set", 1'b1, 6);
        stuck = 6'h00;
        wait_flag("core pad mismatch clear", 1'b0, 6);
        cstuck = 4'h1;
        wait_flag("cache pad mismatch set", 1'b1, 6);
        cstuck = 4'h0;
        wait_flag("cache pad mismatch clear", 1'b0, 6);
    end
    endtask : pad_check

    // Every cycle: code, pads, bound, step size and dwell
    always @(negedge sys_clk)
    begin
        if (armed)
        begin
            check_vec("core code", exp_code(lvl), code);
            check_vec("core pads", exp_code(lvl), core_oe_n);
            check_vec("pad drive", 6'h00, core_out | {2'h0, cch_out});
            check_vec("cache pads", {2'h0, exp_cch}, {2'h0, cch_oe_n});
            check_flag("under default", 1'b1, lvl <= exp_def);
            check_flag("core off", 1'b0, core_off);
            if (lvl !== prev)
            begin
                check_flag("adjacent", 1'b1, lvl == prev + 6'h01 || prev == lvl + 6'h01);
                check_flag("dwell", 1'b1, hold >= DW);
                hold = 1;
            end
            else
                hold++;
            prev = lvl;
        end
    end

    initial
    begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        logic [4:0] s;
        fails = 0;
        checked = 0;
        armed = 0;
        stuck = 6'h00;
        cstuck = 4'h0;
        clk_en = 1;
        rst = 1;
        def_s = 6'h28;
        cch_s = 4'h0;
        pres_s = 1;
        target = 6'h28;
        // All cache straps, then absent cache, then two default straps
        for (s = 5'h00; s < 5'h11; s++)
            boot(6'h28, s[3:0], s != 5'h10);
        boot(6'h10, 4'h3, 1'b1);
        boot(6'h28, 4'h3, 1'b1);
        // Down, reverse mid-way past the default, frozen clock
        step_to(6'h23, 6'h23, 1'b1);
        target = 6'h1E;
        freeze_check();
        step_to(6'h3F, 6'h28, 1'b0);
        // Another party holds a pad low
        pad_check();
        // Clamped default, full sweep of all 62 codes
        boot(6'h3E, 4'h0, 1'b1);
        step_to(6'h00, 6'h00, 1'b1);
        step_to(6'h3F, 6'h3D, 1'b1);
        report_and_stop();
    end
endmodule : vidc_top_tb_top
